/* logic/pcxs_bank.sv */
// PCI-X capability status and split control registers of a bridge.
// Assumes a classic Wishbone master, same-clock bridge event pulses,
// and strap and secondary reset pins from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module pcxs_bank
  import pcxs_pkg::*;
(
  // Clock and reset
  input  wire logic        I_CLOCK,
  input  wire logic        I_SRST,
  // Wishbone slave
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [10:2] I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output logic             O_WB_ACK,
  output logic      [31:0] O_WB_DAT,
  // Straps and secondary reset pin
  input  wire logic [2:0]  I_SEC_FREQ_STRAP,
  input  wire logic [1:0]  I_MODE_STRAP,
  input  wire logic        I_SEC_RST_N,
  // Bridge events
  input  wire logic        I_SPLIT_OVERRUN,
  input  wire logic        I_CPL_DISCARD,
  input  wire logic        I_UNEXP_CPL,
  input  wire logic [7:0]  I_UNEXP_CPL_BUS,
  input  wire logic [4:0]  I_UNEXP_CPL_DEV,
  input  wire logic [2:0]  I_UNEXP_CPL_FUNC,
  input  wire logic [7:0]  I_SEC_BUS_NUM,
  input  wire logic [7:0]  I_PRI_BUS_NUM,
  // Downstream commitment check
  input  wire logic        I_DS_REQ,
  input  wire logic [15:0] I_DS_REQ_SIZE,
  input  wire logic [15:0] I_DS_COMMITTED,
  output logic             O_DS_GRANT,
  // Upstream commitment check
  input  wire logic        I_US_REQ,
  input  wire logic [15:0] I_US_REQ_SIZE,
  input  wire logic [15:0] I_US_COMMITTED,
  output logic             O_US_GRANT,
  // Link 0 received CRC
  input  wire logic        I_LINK0_CRC_LOAD,
  input  wire logic [31:0] I_LINK0_CRC,
  // Status
  output logic      [3:0]  O_SPLIT_FLAGS,
  output logic      [2:0]  O_SEC_FREQ
);

  typedef struct packed {
    logic        ack;
    logic [31:0] rdat;
    logic [2:0]  sec_freq;
    pcxs_mode_t  mode;
    logic [15:0] us_limit;
    logic [15:0] ds_limit;
    logic        ds_grant;
    logic        us_grant;
  } pcxs_state_t;

  pcxs_state_t  st_reg;
  pcxs_state_t  st_next;
  logic [31:0]  crc_reg;
  logic [31:0]  crc_next;
  pcxs_wb_req_t req;
  pcxs_pins_t   pins_raw;
  pcxs_pins_t   pins;
  logic [3:0]   flag_set;
  logic [3:0]   flag_clr;
  logic [3:0]   flags;
  logic         access;
  logic         wr;
  logic         second_fn;
  logic [7:0]   idx;
  logic         mapped;
  logic         ds_fits;
  logic         us_fits;

  // Capability contents appear only in generic modes
  function automatic logic is_generic(input pcxs_mode_t m);
    return (m == single_port_generic_mode) ||
           (m == dual_port_generic_mode);
  endfunction

  // The second function exists only in dual-port modes
  function automatic logic is_dual(input pcxs_mode_t m);
    return (m == dual_port_diag_mode) ||
           (m == dual_port_generic_mode);
  endfunction

  // Commitment check, widened so the sum cannot wrap
  function automatic logic fits(input logic [15:0] committed,
                                input logic [15:0] size,
                                input logic [15:0] limit);
    logic [16:0] total;
    total = {1'b0, committed} + {1'b0, size};
    return total <= {1'b0, limit};
  endfunction

  assign req.cyc = I_WB_CYC;
  assign req.stb = I_WB_STB;
  assign req.we  = I_WB_WE;
  assign req.adr = I_WB_ADR;
  assign req.sel = I_WB_SEL;
  assign req.dat = I_WB_DAT;

  assign pins_raw.sec_rst_n = I_SEC_RST_N;
  assign pins_raw.freq      = I_SEC_FREQ_STRAP;
  assign pins_raw.mode      = I_MODE_STRAP;

  pcxs_sync #(
    .W ($bits(pcxs_pins_t))
  ) u_sync (
    .i_clock (I_CLOCK),
    .i_async (pins_raw),
    .o_sync  (pins)
  );

  // One access per request; ack drops the cycle after it rose
  assign access    = req.cyc & req.stb & ~st_reg.ack;
  assign wr        = access & req.we;
  assign second_fn = req.adr[8];
  assign idx       = req.adr[7:0];
  assign mapped    = ~second_fn | is_dual(st_reg.mode);

  assign ds_fits = fits(I_DS_COMMITTED, I_DS_REQ_SIZE, st_reg.ds_limit);
  assign us_fits = fits(I_US_COMMITTED, I_US_REQ_SIZE, st_reg.us_limit);

  // Flag events
  always_comb begin
    flag_set               = '0;
    flag_set[FLAG_DISCARD] = I_CPL_DISCARD;
    flag_set[FLAG_OVERRUN] = I_SPLIT_OVERRUN;
    flag_set[FLAG_UNEXP]   = I_UNEXP_CPL &
                             (I_UNEXP_CPL_BUS == I_SEC_BUS_NUM) &
                             (I_UNEXP_CPL_DEV == UNEXP_DEV) &
                             (I_UNEXP_CPL_FUNC == UNEXP_FUNC);
    flag_set[FLAG_DELAYED] = I_DS_REQ & ~ds_fits;
  end

  // Clear only on a one written to the low byte lane
  always_comb begin
    flag_clr = '0;
    if (wr && mapped && is_generic(st_reg.mode) &&
        idx == IDX_SEC_STATUS && req.sel[0]) begin
      flag_clr = req.dat[STS_FLAG_LSB +: 4];
    end
  end

  pcxs_sticky #(
    .N (4)
  ) u_sticky (
    .i_clock (I_CLOCK),
    .i_srst  (I_SRST),
    .i_set   (flag_set),
    .i_clr   (flag_clr),
    .o_flags (flags)
  );

  // Next state
  always_comb begin
    st_next          = st_reg;
    st_next.ack      = access;
    st_next.ds_grant = I_DS_REQ & ds_fits;
    st_next.us_grant = I_US_REQ & us_fits;
    // Bus setting follows the straps while secondary reset is held
    if (!pins.sec_rst_n) begin
      st_next.sec_freq = pins.freq;
    end
    // Limits are writable only in generic modes, upper lanes only
    if (wr && mapped && is_generic(st_reg.mode)) begin
      if (idx == IDX_US_CTRL) begin
        if (req.sel[2]) begin
          st_next.us_limit[7:0] = req.dat[23:16];
        end
        if (req.sel[3]) begin
          st_next.us_limit[15:8] = req.dat[31:24];
        end
      end
      if (idx == IDX_DS_CTRL) begin
        if (req.sel[2]) begin
          st_next.ds_limit[7:0] = req.dat[23:16];
        end
        if (req.sel[3]) begin
          st_next.ds_limit[15:8] = req.dat[31:24];
        end
      end
    end
    // Read data; unmapped and reserved locations read zero
    st_next.rdat = '0;
    if (access && !req.we && mapped) begin
      if (is_generic(st_reg.mode)) begin
        unique case (idx)
          IDX_LINK0_CRC: begin
            st_next.rdat[7:0] = CAP_ID;
          end
          IDX_CAP_PTR: begin
            st_next.rdat[7:0] = NEXT_PTR;
          end
          IDX_SEC_STATUS: begin
            st_next.rdat[STS_FREQ_LSB +: 3] = st_reg.sec_freq;
            st_next.rdat[STS_FLAG_LSB +: 4] = flags;
            st_next.rdat[STS_133_BIT]       = 1'b1;
            st_next.rdat[STS_WIDTH_BIT]     = ~second_fn;
          end
          IDX_BRIDGE: begin
            st_next.rdat[BRG_BUS_LSB +: 8] = I_PRI_BUS_NUM;
            st_next.rdat[BRG_DEV_LSB +: 5] = DEVICE_NUM;
            st_next.rdat[2:0]              = FUNC_NUM;
          end
          IDX_US_CTRL: begin
            st_next.rdat[LIMIT_LSB +: 16] = st_reg.us_limit;
            st_next.rdat[15:0]            = CAPACITY;
          end
          IDX_DS_CTRL: begin
            st_next.rdat[LIMIT_LSB +: 16] = st_reg.ds_limit;
            st_next.rdat[15:0]            = CAPACITY;
          end
          default: begin
            st_next.rdat = '0;
          end
        endcase
      end else if (idx == IDX_LINK0_CRC) begin
        st_next.rdat = crc_reg;
      end
    end
  end

  // CRC register is outside the reset so it survives warm reset
  always_comb begin
    crc_next = crc_reg;
    if (I_LINK0_CRC_LOAD) begin
      crc_next = I_LINK0_CRC;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    crc_reg <= crc_next;
  end

  // Mode straps are sampled during reset and frozen after it
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      st_reg          <= '0;
      st_reg.mode     <= pcxs_mode_t'(pins.mode);
      st_reg.sec_freq <= pins.freq;
      st_reg.us_limit <= LIMIT_RST;
      st_reg.ds_limit <= LIMIT_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign O_WB_ACK      = st_reg.ack;
  assign O_WB_DAT      = st_reg.rdat;
  assign O_DS_GRANT    = st_reg.ds_grant;
  assign O_US_GRANT    = st_reg.us_grant;
  assign O_SPLIT_FLAGS = flags;
  assign O_SEC_FREQ    = st_reg.sec_freq;

endmodule
`default_nettype wire

/* logic/pcxs_pkg.sv */
// Package for the PCI-X capability status register bank.
// Assumes a 32-bit classic Wishbone slave, one clock.
package pcxs_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_LINK0_CRC  = 8'hF0;
  localparam logic [7:0] IDX_CAP_PTR    = 8'hF1;
  localparam logic [7:0] IDX_SEC_STATUS = 8'hF2;
  localparam logic [7:0] IDX_BRIDGE     = 8'hF4;
  localparam logic [7:0] IDX_US_CTRL    = 8'hF8;
  localparam logic [7:0] IDX_DS_CTRL    = 8'hFC;

  // Secondary status fields
  localparam int STS_WIDTH_BIT = 0;
  localparam int STS_133_BIT   = 1;
  localparam int STS_FLAG_LSB  = 2;
  localparam int STS_FREQ_LSB  = 6;

  // Sticky flag positions within the four-bit flag group
  localparam int FLAG_DISCARD = 0;
  localparam int FLAG_UNEXP   = 1;
  localparam int FLAG_OVERRUN = 2;
  localparam int FLAG_DELAYED = 3;

  // Bridge identity fields
  localparam int          BRG_BUS_LSB = 8;
  localparam int          BRG_DEV_LSB = 3;
  localparam logic [4:0]  DEVICE_NUM  = 5'h1F;
  localparam logic [2:0]  FUNC_NUM    = 3'h0;
  localparam logic [4:0]  UNEXP_DEV   = 5'h00;
  localparam logic [2:0]  UNEXP_FUNC  = 3'h0;

  // Split control fields and reset values
  localparam int          LIMIT_LSB  = 16;
  localparam logic [15:0] LIMIT_RST  = 16'h0006;
  localparam logic [15:0] CAPACITY   = 16'h0005;
  localparam logic [7:0]  CAP_ID     = 8'h07;
  localparam logic [7:0]  NEXT_PTR   = 8'h00;

  typedef enum logic [1:0] {
    single_port_diag_mode,
    dual_port_diag_mode,
    single_port_generic_mode,
    dual_port_generic_mode
  } pcxs_mode_t;

  // Wishbone request as seen by the slave
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [8:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } pcxs_wb_req_t;

  // Pins that cross into the clock domain
  typedef struct packed {
    logic       sec_rst_n;
    logic [2:0] freq;
    logic [1:0] mode;
  } pcxs_pins_t;

endpackage

/* logic/pcxs_sticky.sv */
// Bank of sticky status flags, set by hardware, cleared by writing one.
// Assumes set and clear pulses on the same clock.
`timescale 1ns/1ps
`default_nettype none
module pcxs_sticky #(
  parameter int N = 4
) (
  // Clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_srst,
  // Events and clears
  input  wire logic [N-1:0] i_set,
  input  wire logic [N-1:0] i_clr,
  output logic      [N-1:0] o_flags
);
  typedef struct packed {
    logic [N-1:0] flags;
  } pcxs_sticky_t;

  pcxs_sticky_t st_reg;
  pcxs_sticky_t st_next;

  // Set wins so an event in the clearing cycle is kept
  always_comb begin
    st_next = st_reg;
    for (int k = 0; k < N; k++) begin
      st_next.flags[k] = i_set[k] | (st_reg.flags[k] & ~i_clr[k]);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_flags = st_reg.flags;
endmodule
`default_nettype wire

/* logic/pcxs_sync.sv */
// Two-flop synchroniser for a group of pin levels.
// Assumes level inputs that may change at any time.
`timescale 1ns/1ps
`default_nettype none
module pcxs_sync #(
  parameter int W = 6
) (
  // Clock
  input  wire logic         i_clock,
  // Levels
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } pcxs_sync_t;

  pcxs_sync_t st_reg;
  pcxs_sync_t st_next;

  always_comb begin
    st_next.meta = i_async;
    st_next.sync = st_reg.meta;
  end

  // No reset: straps must reach the bank while it is held in reset
  always_ff @(posedge i_clock) begin
    st_reg <= st_next;
  end

  assign o_sync = st_reg.sync;
endmodule
`default_nettype wire

/* verification/pcxs_bank_assertions.sv */
// Assertion checker for the capability register bank ports.
// Assumes binding into pcxs_bank, one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module pcxs_bank_assertions
  import pcxs_pkg::*;
(
  // Clock and reset
  input wire logic       I_CLOCK,
  input wire logic       I_SRST,
  // Bus, pins and events
  input wire logic       I_WB_CYC,
  input wire logic       I_WB_STB,
  input wire logic       I_WB_WE,
  input wire logic       I_SPLIT_OVERRUN,
  input wire logic       I_CPL_DISCARD,
  input wire logic       I_UNEXP_CPL,
  input wire logic [7:0] I_UNEXP_CPL_BUS,
  input wire logic [4:0] I_UNEXP_CPL_DEV,
  input wire logic [2:0] I_UNEXP_CPL_FUNC,
  input wire logic [7:0] I_SEC_BUS_NUM,
  input wire logic       I_SEC_RST_N,
  input wire logic       I_DS_REQ,
  input wire logic       I_US_REQ,
  // Outputs watched
  input wire logic       O_WB_ACK,
  input wire logic       O_DS_GRANT,
  input wire logic       O_US_GRANT,
  input wire logic [3:0] O_SPLIT_FLAGS,
  input wire logic [2:0] O_SEC_FREQ
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SRST);
  wire logic wr = I_WB_CYC && I_WB_STB && I_WB_WE;
  wire logic hit = I_UNEXP_CPL && I_UNEXP_CPL_BUS == I_SEC_BUS_NUM
                   && I_UNEXP_CPL_DEV == UNEXP_DEV
                   && I_UNEXP_CPL_FUNC == UNEXP_FUNC;

  AST_ACK_ANSWER: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK
    |=> O_WB_ACK) else $error("no ack after request");
  AST_ACK_PULSE: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack longer than one cycle");
  AST_OVERRUN_SET: assert property (I_SPLIT_OVERRUN
    |=> O_SPLIT_FLAGS[FLAG_OVERRUN]) else $error("overrun flag not set");
  AST_DISCARD_SET: assert property (I_CPL_DISCARD
    |=> O_SPLIT_FLAGS[FLAG_DISCARD]) else $error("discard flag not set");
  AST_UNEXP_SET: assert property (hit
    |=> O_SPLIT_FLAGS[FLAG_UNEXP]) else $error("unexpected flag not set");
  AST_FLAGS_HOLD: assert property (!wr && !I_SPLIT_OVERRUN
    && !I_CPL_DISCARD && !I_UNEXP_CPL && !I_DS_REQ
    |=> $stable(O_SPLIT_FLAGS)) else $error("flags moved without cause");
  AST_DS_DELAYED: assert property (I_DS_REQ
    |=> O_DS_GRANT || O_SPLIT_FLAGS[FLAG_DELAYED])
    else $error("refused request left no delayed flag");
  AST_DS_CAUSE: assert property (!I_DS_REQ |=> !O_DS_GRANT)
    else $error("downstream grant without request");
  AST_US_CAUSE: assert property (!I_US_REQ |=> !O_US_GRANT)
    else $error("upstream grant without request");
  AST_FREQ_HELD: assert property (I_SEC_RST_N [*6]
    |=> $stable(O_SEC_FREQ)) else $error("bus setting moved");
endmodule
bind pcxs_bank pcxs_bank_assertions u_chk (
  .I_CLOCK(I_CLOCK), .I_SRST(I_SRST), .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_SPLIT_OVERRUN(I_SPLIT_OVERRUN),
  .I_CPL_DISCARD(I_CPL_DISCARD), .I_UNEXP_CPL(I_UNEXP_CPL),
  .I_UNEXP_CPL_BUS(I_UNEXP_CPL_BUS), .I_UNEXP_CPL_DEV(I_UNEXP_CPL_DEV),
  .I_UNEXP_CPL_FUNC(I_UNEXP_CPL_FUNC), .I_SEC_BUS_NUM(I_SEC_BUS_NUM),
  .I_SEC_RST_N(I_SEC_RST_N), .I_DS_REQ(I_DS_REQ), .I_US_REQ(I_US_REQ),
  .O_WB_ACK(O_WB_ACK), .O_DS_GRANT(O_DS_GRANT), .O_US_GRANT(O_US_GRANT),
  .O_SPLIT_FLAGS(O_SPLIT_FLAGS), .O_SEC_FREQ(O_SEC_FREQ));
`default_nettype wire

/* verification/pcxs_bank_tb.sv */
// Self-checking bench for the capability register bank.
// Assumes the bound checker; drives every port directly.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  n_mismatch++; $display("BAD %0t got %h want %h", $time, g, e); end end
module pcxs_bank_tb
  import pcxs_pkg::*;
;
  logic        clk, srst, cyc, stb, wen, sec_rst_n, ovr, dis, unx;
  logic        ds_req, us_req, crc_ld, ack, ds_grant, us_grant;
  logic [8:0]  adr;
  logic [3:0]  sel, flags;
  logic [31:0] wdat, crc, rdat, c, q;
  logic [2:0]  freq, ufunc, sec_freq, f;
  logic [1:0]  mode;
  logic [7:0]  ubus, sec_bus, pri_bus;
  logic [4:0]  udev;
  logic [15:0] size, com, l;
  int          seed, m, cycles, n_mismatch, samples_checked;

  pcxs_bank u_dut (
    .I_CLOCK(clk), .I_SRST(srst), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(wen), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
    .O_WB_ACK(ack), .O_WB_DAT(rdat), .I_SEC_FREQ_STRAP(freq),
    .I_MODE_STRAP(mode), .I_SEC_RST_N(sec_rst_n), .I_SPLIT_OVERRUN(ovr),
    .I_CPL_DISCARD(dis), .I_UNEXP_CPL(unx), .I_UNEXP_CPL_BUS(ubus),
    .I_UNEXP_CPL_DEV(udev), .I_UNEXP_CPL_FUNC(ufunc),
    .I_SEC_BUS_NUM(sec_bus), .I_PRI_BUS_NUM(pri_bus), .I_DS_REQ(ds_req),
    .I_DS_REQ_SIZE(size), .I_DS_COMMITTED(com), .O_DS_GRANT(ds_grant),
    .I_US_REQ(us_req), .I_US_REQ_SIZE(size), .I_US_COMMITTED(com),
    .O_US_GRANT(us_grant), .I_LINK0_CRC_LOAD(crc_ld), .I_LINK0_CRC(crc),
    .O_SPLIT_FLAGS(flags), .O_SEC_FREQ(sec_freq));

  always #50 clk = ~clk;

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Hang guard; the full run needs under two thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic wb(input logic w, input logic [8:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    wen <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [8:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 4'hF, 32'h0, r);
    `CHK(r, e)
  endtask

  // Straps held past the synchroniser, then the frequency strap moved to prove the capture
  task automatic boot(input logic [1:0] md, input logic [2:0] fr);
    mode <= md;
    freq <= fr;
    sec_rst_n <= 1'b0;
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    sec_rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    freq <= ~fr;
    repeat (6) @(posedge clk);
  endtask

  task automatic ev(input logic [2:0] e, input logic [3:0] x);
    {ovr, dis, unx} <= e;
    @(posedge clk);
    {ovr, dis, unx} <= 3'h0;
    @(posedge clk);
    `CHK(flags, x)
  endtask

  task automatic req(input logic d, input logic [15:0] cm, input logic x);
    ds_req <= d;
    us_req <= !d;
    size <= l;
    com <= cm;
    @(posedge clk);
    ds_req <= 1'b0;
    us_req <= 1'b0;
    @(posedge clk);
    `CHK(d ? ds_grant : us_grant, x)
  endtask

  initial begin
    seed = 3;
    {clk, cyc, stb, wen, ovr, dis, unx, ds_req, us_req, crc_ld} = '0;
    {adr, sel, wdat, crc, freq, mode, ubus, udev, ufunc} = '0;
    {sec_bus, pri_bus, size, com, sec_rst_n} = '0;
    srst = 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (m = 0; m < 4; m++) begin
      f = 3'($random(seed));
      boot(2'(m), f);
      `CHK(sec_freq, f)
      if (m < 2) begin
        if (m == 1) rd({1'b0, IDX_LINK0_CRC}, c);
        c = $random(seed);
        crc <= c;
        crc_ld <= 1'b1;
        @(posedge clk);
        crc_ld <= 1'b0;
        rd({1'b0, IDX_LINK0_CRC}, c);
        wb(1'b1, {1'b0, IDX_US_CTRL}, 4'hF, c, q);
        rd({1'b0, IDX_US_CTRL}, 32'h0);
      end else begin
        pri_bus <= 8'($random(seed));
        sec_bus <= 8'($random(seed));
        rd({1'b0, IDX_LINK0_CRC}, {24'h0, CAP_ID});
        rd({1'b0, IDX_SEC_STATUS}, {23'h0, f, 6'h03});
        rd({1'b1, IDX_SEC_STATUS}, m == 3 ? {23'h0, f, 6'h02} : 0);
        c = {16'h0, pri_bus, DEVICE_NUM, FUNC_NUM};
        rd({1'b0, IDX_BRIDGE}, c);
        wb(1'b1, {1'b0, IDX_BRIDGE}, 4'hF, $random(seed), q);
        rd({1'b0, IDX_BRIDGE}, c);
        rd({1'b0, IDX_US_CTRL}, {LIMIT_RST, CAPACITY});
        rd({1'b0, IDX_DS_CTRL}, {LIMIT_RST, CAPACITY});
        l = 16'($random(seed));
        wb(1'b1, {1'b0, IDX_DS_CTRL}, 4'h3, {l, 16'hFFFF}, q);
        rd({1'b0, IDX_DS_CTRL}, {LIMIT_RST, CAPACITY});
        wb(1'b1, {1'b0, IDX_DS_CTRL}, 4'hF, {l, 16'hFFFF}, q);
        rd({1'b0, IDX_DS_CTRL}, {l, CAPACITY});
        wb(1'b1, {1'b0, IDX_US_CTRL}, 4'hC, {l, 16'h0000}, q);
        rd({1'b0, IDX_US_CTRL}, {l, CAPACITY});
        req(1'b1, 16'h0, 1'b1);
        `CHK(flags, 4'h0)
        req(1'b1, 16'h1, 1'b0);
        `CHK(flags, 4'h8)
        req(1'b0, 16'h0, 1'b1);
        req(1'b0, 16'h1, 1'b0);
        ev(3'b100, 4'hC);
        ev(3'b010, 4'hD);
        ubus <= sec_bus;
        udev <= 5'h01;
        ev(3'b001, 4'hD);
        udev <= UNEXP_DEV;
        ev(3'b001, 4'hF);
        wb(1'b1, {1'b0, IDX_SEC_STATUS}, 4'hF, 32'h0, q);
        `CHK(flags, 4'hF)
        wb(1'b1, {1'b0, IDX_SEC_STATUS}, 4'hF, 32'h14, q);
        `CHK(flags, 4'hA)
        wb(1'b1, {1'b0, IDX_SEC_STATUS}, 4'hF, 32'h28, q);
        `CHK(flags, 4'h0)
        rd({1'b0, 8'h10}, 32'h0);
      end
    end
    print_verdict();
  end
endmodule
`default_nettype wire
